// >>> hdl/pulse_counter_pkg.sv
// Package for the four-channel single-phase pulse counter.
// Holds the register map, field positions, modes and widths; assumes a 32-bit AHB-Lite bus.
package pulse_counter_pkg;
	localparam int CH_NUM = 4;
	localparam int WORD_W = 32;
	localparam int HALF_W = 16;
	localparam int ADDR_W = 8;
	localparam int CH_SEL_LSB = 6;
	localparam int EV_W = 5;
	localparam logic [WORD_W-1:0] COUNT_MAX = 32'hffffffff;
	localparam logic [WORD_W-1:0] COUNT_ZERO = 32'h00000000;
	localparam logic [HALF_W-1:0] HALF_ZERO = 16'h0000;

	// Word offsets inside one channel's 64-byte window
	localparam logic [5:0] OFF_COUNT_NOW_UPPER = 6'h00;
	localparam logic [5:0] OFF_COUNT_NOW_LOWER = 6'h04;
	localparam logic [5:0] OFF_TARGET_ONE_UPPER = 6'h08;
	localparam logic [5:0] OFF_TARGET_ONE_LOWER = 6'h0c;
	localparam logic [5:0] OFF_TARGET_TWO_UPPER = 6'h10;
	localparam logic [5:0] OFF_TARGET_TWO_LOWER = 6'h14;
	localparam logic [5:0] OFF_RELOAD_VALUE_UPPER = 6'h18;
	localparam logic [5:0] OFF_RELOAD_VALUE_LOWER = 6'h1c;
	localparam logic [5:0] OFF_CONTROL = 6'h20;
	localparam logic [5:0] OFF_COMMAND = 6'h24;
	localparam logic [5:0] OFF_STATUS = 6'h28;

	// Control word fields
	localparam int CTL_MODE_LSB = 0;
	localparam int CTL_MODE_MSB = 1;
	localparam int CTL_GATE = 2;
	localparam int CTL_KEEP_ONE = 3;
	localparam int CTL_KEEP_TWO = 4;
	localparam int CTL_OUT_EN = 5;
	localparam int CTL_W = 6;
	localparam logic [CTL_W-1:0] CTL_RESET = 6'h00;

	// Command word fields, write-one pulses
	localparam int CMD_OUT_CLEAR = 0;
	localparam int CMD_SOFT_RESET = 1;

	// Event and status bit positions
	localparam int EV_PIN = 0;
	localparam int EV_ONE = 1;
	localparam int EV_TWO = 2;
	localparam int EV_OVF = 3;
	localparam int EV_UDF = 4;
	localparam int STAT_OUT = 5;

	typedef enum logic [1:0] {
		MODE_ADD = 2'h0,
		MODE_DUAL = 2'h1,
		MODE_UPDN = 2'h2
	} count_mode_t;
endpackage

// >>> hdl/single_phase_pulse_counter.sv
// Four-channel single-phase pulse counter with an AHB-Lite register slave.
// Assumes pulse and pin inputs synchronous to mclk, and a one-cycle scan_tick per controller scan.
//
// Contract
// - adding everywhere; reversible modes on channels 1, 4
// - adding mode counts each pulse rising edge
// - two presets; keep or reload on one
// - keep continues to preset two, then max
// - channels 2, 3 clear to zero at preset
// - dual mode: up pulse adds, down subtracts
// - reversible modes reload on reaching zero downward
// - downward preset hits act like upward ones
// - direction input on counts up, off down
// - direction mode compares like dual mode
// - current value copied once per scan
// - soft reset loads reload value or zero
// - counting only while gate is on
// - presets take effect on the following cycle; code loads them only at the next reload
// - clear relay turns comparison output off
// - pin reset raises pin status, soft not
// - status bits last exactly one scan
// - upper half in lower-numbered word
// - comparison output holds until cleared
`timescale 1ns/10ps
`default_nettype none
module single_phase_pulse_counter
	import pulse_counter_pkg::*;
(
	input wire logic mclk,
	input wire logic rstn,
	input wire logic ce,
	input wire logic scan_tick,
	input wire logic [CH_NUM-1:0] pulse_in,
	input wire logic [CH_NUM-1:0] aux_in,
	input wire logic reset_pin_ch1,
	input wire logic reset_pin_ch4,
	output logic [CH_NUM-1:0] compare_out,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp
);
	typedef struct packed {
		logic [CH_NUM-1:0] a_s1;
		logic [CH_NUM-1:0] a_s2;
		logic [CH_NUM-1:0] a_prev;
		logic [CH_NUM-1:0] b_s1;
		logic [CH_NUM-1:0] b_s2;
		logic [CH_NUM-1:0] b_prev;
		logic [CH_NUM-1:0] p_s1;
		logic [CH_NUM-1:0] p_s2;
		logic [CH_NUM-1:0] p_prev;
		logic [CH_NUM-1:0][WORD_W-1:0] count;
		logic [CH_NUM-1:0][WORD_W-1:0] snap;
		logic [CH_NUM-1:0][WORD_W-1:0] act_one;
		logic [CH_NUM-1:0][WORD_W-1:0] act_two;
		logic [CH_NUM-1:0][WORD_W-1:0] target_one;
		logic [CH_NUM-1:0][WORD_W-1:0] target_two;
		logic [CH_NUM-1:0][WORD_W-1:0] reload_value;
		logic [CH_NUM-1:0][CTL_W-1:0] ctrl;
		logic [CH_NUM-1:0][EV_W-1:0] pend;
		logic [CH_NUM-1:0][EV_W-1:0] status;
		logic [CH_NUM-1:0] cmp_out;
		logic ap_valid;
		logic ap_write;
		logic [ADDR_W-1:0] ap_addr;
		logic [WORD_W-1:0] rdata;
	} state_t;

	state_t st_reg;
	state_t st_next;
	logic [CH_NUM-1:0] soft_p;
	logic [CH_NUM-1:0] clr_p;
	logic [CH_NUM-1:0] up_p;
	logic [CH_NUM-1:0] dn_p;
	logic [CH_NUM-1:0] pin_rise;
	logic [CH_NUM-1:0] pin_vec;
	logic [CH_NUM-1:0][EV_W-1:0] ev;

	// Only the multimode channels have a hardware reset pin
	assign pin_vec = {reset_pin_ch4, 1'b0, 1'b0, reset_pin_ch1};

	// Zero-wait slave; a low clock enable stalls the bus with the rest of the block
	assign hreadyout = ce;
	assign hresp = 1'b0;
	assign hrdata = st_reg.rdata;
	assign compare_out = st_reg.cmp_out;

	always_comb
	begin
		logic multi;
		logic a_rise;
		logic b_rise;
		logic reload;
		logic [1:0] md;
		logic [5:0] off;
		logic [1:0] ch;
		logic wr;
		logic [WORD_W-1:0] nv;
		logic [WORD_W-1:0] rv;
		multi = 1'b0;
		a_rise = 1'b0;
		b_rise = 1'b0;
		reload = 1'b0;
		md = MODE_ADD;
		nv = COUNT_ZERO;
		rv = COUNT_ZERO;
		off = '0;
		ch = '0;
		wr = 1'b0;
		st_next = st_reg;
		soft_p = '0;
		clr_p = '0;
		up_p = '0;
		dn_p = '0;
		pin_rise = '0;
		ev = '0;

		// Input synchronisers; first stage feeds only the second
		st_next.a_s1 = pulse_in;
		st_next.a_s2 = st_reg.a_s1;
		st_next.a_prev = st_reg.a_s2;
		st_next.b_s1 = aux_in;
		st_next.b_s2 = st_reg.b_s1;
		st_next.b_prev = st_reg.b_s2;
		st_next.p_s1 = pin_vec;
		st_next.p_s2 = st_reg.p_s1;
		st_next.p_prev = st_reg.p_s2;

		// Data phase write, decoded once for all channels
		wr = st_reg.ap_valid && st_reg.ap_write;
		ch = st_reg.ap_addr[ADDR_W-1:CH_SEL_LSB];
		off = st_reg.ap_addr[CH_SEL_LSB-1:0];
		if (wr)
		begin
			case (off)
				OFF_TARGET_ONE_UPPER: st_next.target_one[ch][WORD_W-1:HALF_W] = hwdata[HALF_W-1:0];
				OFF_TARGET_ONE_LOWER: st_next.target_one[ch][HALF_W-1:0] = hwdata[HALF_W-1:0];
				OFF_TARGET_TWO_UPPER: st_next.target_two[ch][WORD_W-1:HALF_W] = hwdata[HALF_W-1:0];
				OFF_TARGET_TWO_LOWER: st_next.target_two[ch][HALF_W-1:0] = hwdata[HALF_W-1:0];
				OFF_RELOAD_VALUE_UPPER: st_next.reload_value[ch][WORD_W-1:HALF_W] = hwdata[HALF_W-1:0];
				OFF_RELOAD_VALUE_LOWER: st_next.reload_value[ch][HALF_W-1:0] = hwdata[HALF_W-1:0];
				OFF_CONTROL: st_next.ctrl[ch] = hwdata[CTL_W-1:0];
				OFF_COMMAND:
				begin
					clr_p[ch] = hwdata[CMD_OUT_CLEAR];
					soft_p[ch] = hwdata[CMD_SOFT_RESET];
				end
				default: ;
			endcase
		end

		// Per-channel counting, comparison and status
		for (int i = 0; i < CH_NUM; i++)
		begin
			multi = (i == 0) || (i == CH_NUM - 1);
			md = multi ? st_reg.ctrl[i][CTL_MODE_MSB:CTL_MODE_LSB] : MODE_ADD;
			a_rise = st_reg.a_s2[i] && !st_reg.a_prev[i];
			b_rise = st_reg.b_s2[i] && !st_reg.b_prev[i];
			pin_rise[i] = multi && st_reg.p_s2[i] && !st_reg.p_prev[i];
			case (md)
				MODE_ADD: up_p[i] = a_rise;
				MODE_DUAL:
				begin
					// Simultaneous up and down edges cancel out
					up_p[i] = a_rise && !b_rise;
					dn_p[i] = b_rise && !a_rise;
				end
				MODE_UPDN:
				begin
					up_p[i] = a_rise && st_reg.b_s2[i];
					dn_p[i] = a_rise && !st_reg.b_s2[i];
				end
				default: ;
			endcase
			if (!st_reg.ctrl[i][CTL_GATE])
			begin
				up_p[i] = 1'b0;
				dn_p[i] = 1'b0;
			end
			// Adding-only channels always restart from zero
			rv = multi ? st_reg.reload_value[i] : COUNT_ZERO;
			reload = 1'b0;
			nv = st_reg.count[i];
			// Pin reset outranks soft reset and counting
			if (pin_rise[i])
			begin
				reload = 1'b1;
				ev[i][EV_PIN] = 1'b1;
			end
			else if (soft_p[i])
			begin
				reload = 1'b1;
			end
			else if (up_p[i] && !multi)
			begin
				nv = st_reg.count[i] + 32'h00000001;
				if (nv == st_reg.act_one[i])
				begin
					ev[i][EV_ONE] = 1'b1;
					reload = 1'b1;
				end
			end
			// On multimode channels stepping past the top restarts from the reload value; adding-only channels wrap to zero
			else if (up_p[i] && st_reg.count[i] == COUNT_MAX)
			begin
				ev[i][EV_OVF] = 1'b1;
				reload = 1'b1;
			end
			else if (up_p[i] || dn_p[i])
			begin
				nv = up_p[i] ? st_reg.count[i] + 32'h00000001 : st_reg.count[i] - 32'h00000001;
				// Presets hit in either direction; several may fire together
				if (nv == st_reg.act_one[i])
				begin
					ev[i][EV_ONE] = 1'b1;
					reload = reload || !st_reg.ctrl[i][CTL_KEEP_ONE];
				end
				if (nv == st_reg.act_two[i])
				begin
					ev[i][EV_TWO] = 1'b1;
					reload = reload || !st_reg.ctrl[i][CTL_KEEP_TWO];
				end
				if (dn_p[i] && nv == COUNT_ZERO)
				begin
					ev[i][EV_UDF] = 1'b1;
					reload = 1'b1;
				end
			end
			// New counting cycle picks up the preset registers
			if (reload)
			begin
				nv = rv;
				st_next.act_one[i] = st_reg.target_one[i];
				st_next.act_two[i] = st_reg.target_two[i];
			end
			st_next.count[i] = nv;

			// Set wins over a clear in the same cycle
			if (clr_p[i])
				st_next.cmp_out[i] = 1'b0;
			if (st_reg.ctrl[i][CTL_OUT_EN] && |ev[i][EV_UDF:EV_ONE])
				st_next.cmp_out[i] = 1'b1;

			// Events gather between scans and show for one whole scan
			if (scan_tick)
			begin
				st_next.status[i] = st_reg.pend[i] | ev[i];
				st_next.pend[i] = '0;
				st_next.snap[i] = nv;
			end
			else
				st_next.pend[i] = st_reg.pend[i] | ev[i];
		end

		// Address phase capture and registered read data
		st_next.ap_valid = hsel && htrans[1] && hready;
		st_next.ap_write = hwrite;
		st_next.ap_addr = haddr[ADDR_W-1:0];
		if (hsel && htrans[1] && hready && !hwrite)
		begin
			ch = haddr[ADDR_W-1:CH_SEL_LSB];
			off = haddr[CH_SEL_LSB-1:0];
			case (off)
				OFF_COUNT_NOW_UPPER: st_next.rdata = {HALF_ZERO, st_reg.snap[ch][WORD_W-1:HALF_W]};
				OFF_COUNT_NOW_LOWER: st_next.rdata = {HALF_ZERO, st_reg.snap[ch][HALF_W-1:0]};
				OFF_TARGET_ONE_UPPER: st_next.rdata = {HALF_ZERO, st_reg.target_one[ch][WORD_W-1:HALF_W]};
				OFF_TARGET_ONE_LOWER: st_next.rdata = {HALF_ZERO, st_reg.target_one[ch][HALF_W-1:0]};
				OFF_TARGET_TWO_UPPER: st_next.rdata = {HALF_ZERO, st_reg.target_two[ch][WORD_W-1:HALF_W]};
				OFF_TARGET_TWO_LOWER: st_next.rdata = {HALF_ZERO, st_reg.target_two[ch][HALF_W-1:0]};
				OFF_RELOAD_VALUE_UPPER: st_next.rdata = {HALF_ZERO, st_reg.reload_value[ch][WORD_W-1:HALF_W]};
				OFF_RELOAD_VALUE_LOWER: st_next.rdata = {HALF_ZERO, st_reg.reload_value[ch][HALF_W-1:0]};
				OFF_CONTROL: st_next.rdata = {{(WORD_W-CTL_W){1'b0}}, st_reg.ctrl[ch]};
				OFF_STATUS: st_next.rdata = {{(WORD_W-EV_W-1){1'b0}}, st_reg.cmp_out[ch], st_reg.status[ch]};
				default: st_next.rdata = COUNT_ZERO;
			endcase
		end
	end

	// Single state register; clock enable freezes everything
	always_ff @(posedge mclk)
	begin
		if (!rstn)
		begin
			st_reg <= '0;
		end
		else if (ce)
		begin
			st_reg <= st_next;
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstn || !ce);

	// Channel two adding step with no reset pending
	sequence ch2_step_s;
		up_p[1] && !soft_p[1] && ce;
	endsequence

	sequence ch2_hit_s;
		ch2_step_s ##0 (st_reg.count[1] + 32'h00000001 == st_reg.act_one[1]);
	endsequence

	gate_blocks_count_a: assert property (!st_reg.ctrl[1][CTL_GATE] && !soft_p[1] |=> $stable(st_reg.count[1]))
		else $error("count moved while gate off");
	add_step_a: assert property (ch2_step_s ##0 (st_reg.count[1] + 32'h00000001 != st_reg.act_one[1])
		|=> st_reg.count[1] == $past(st_reg.count[1]) + 32'h00000001)
		else $error("adding step wrong");
	preset_zero_a: assert property (ch2_hit_s
		|=> st_reg.count[1] == COUNT_ZERO ##0 (st_reg.pend[1][EV_ONE] || $past(scan_tick)))
		else $error("preset did not clear count");
	soft_reset_a: assert property (soft_p[0] && !pin_rise[0] |=> st_reg.count[0] == $past(st_reg.reload_value[0]))
		else $error("soft reset value wrong");
	snap_hold_a: assert property (!scan_tick |=> $stable(st_reg.snap) && $stable(st_reg.status))
		else $error("snapshot or status moved between scans");
	status_scan_a: assert property (scan_tick && |st_reg.pend[1] |=> |st_reg.status[1])
		else $error("pending event not shown");
	pin_status_a: assert property (pin_rise[0] && !scan_tick |=> st_reg.pend[0][EV_PIN])
		else $error("pin reset status missing");
	soft_no_pin_a: assert property (soft_p[3] && !pin_rise[3] && !st_reg.pend[3][EV_PIN] && !scan_tick
		|=> !st_reg.pend[3][EV_PIN])
		else $error("soft reset raised pin status");
	out_hold_a: assert property (st_reg.cmp_out[0] && !clr_p[0] |=> st_reg.cmp_out[0])
		else $error("comparison output dropped");
	out_clear_a: assert property (clr_p[1] && !(st_reg.ctrl[1][CTL_OUT_EN] && |ev[1][EV_UDF:EV_ONE])
		|=> !st_reg.cmp_out[1])
		else $error("clear did not drop output");
	updn_dir_a: assert property (st_reg.ctrl[3][CTL_MODE_MSB:CTL_MODE_LSB] == MODE_UPDN && up_p[3]
		|-> st_reg.b_s2[3])
		else $error("direction ignored");
	sync_edge_a: assert property (up_p[1] |-> st_reg.a_s2[1] && !st_reg.a_prev[1])
		else $error("count without rising edge");

	// Multimode channel one upward step below the top, no reset pending
	sequence ch0_up_s;
		up_p[0] && !pin_rise[0] && !soft_p[0] && st_reg.count[0] != COUNT_MAX;
	endsequence

	// Multimode channel one last downward step onto zero
	sequence ch0_down_s;
		dn_p[0] && !pin_rise[0] && !soft_p[0] && st_reg.count[0] == 32'h00000001;
	endsequence

	// Reloads use past register values, since software may rewrite them later
	ovf_reload_a: assert property (up_p[0] && !pin_rise[0] && !soft_p[0] && st_reg.count[0] == COUNT_MAX
		|=> st_reg.count[0] == $past(st_reg.reload_value[0]))
		else $error("overflow did not reload");
	udf_reload_a: assert property (ch0_down_s |=> st_reg.count[0] == $past(st_reg.reload_value[0]))
		else $error("underflow did not reload");
	udf_flag_a: assert property (ch0_down_s |=> st_reg.pend[0][EV_UDF] || st_reg.status[0][EV_UDF])
		else $error("underflow not flagged");
	pin_first_a: assert property (pin_rise[0] |=> st_reg.count[0] == $past(st_reg.reload_value[0]))
		else $error("pin reset value wrong");

	// Keep, snapshot, soft reset, output, status and direction-step checks
	keep_one_a: assert property (ch0_up_s ##0 st_reg.ctrl[0][CTL_KEEP_ONE]
		##0 (st_reg.count[0] + 32'h00000001 == st_reg.act_one[0])
		##0 (st_reg.count[0] + 32'h00000001 != st_reg.act_two[0])
		|=> st_reg.count[0] == $past(st_reg.count[0]) + 32'h00000001)
		else $error("keep did not hold count");
	snap_load_a: assert property (scan_tick |=> st_reg.snap[0] == st_reg.count[0])
		else $error("snapshot not taken at scan");
	soft_zero_a: assert property (soft_p[1] |=> st_reg.count[1] == COUNT_ZERO)
		else $error("soft reset did not clear");
	act_load_a: assert property (soft_p[1] |=> st_reg.act_one[1] == $past(st_reg.target_one[1]))
		else $error("preset not taken for new cycle");
	out_set_a: assert property (st_reg.ctrl[1][CTL_OUT_EN] && ev[1][EV_ONE] |=> st_reg.cmp_out[1])
		else $error("comparison output not set");
	status_clear_a: assert property (scan_tick && !(|st_reg.pend[1]) && !(|ev[1]) |=> st_reg.status[1] == '0)
		else $error("status outlived its scan");
	dual_down_a: assert property (st_reg.ctrl[0][CTL_MODE_MSB:CTL_MODE_LSB] == MODE_DUAL && dn_p[0]
		|-> st_reg.b_s2[0] && !st_reg.b_prev[0])
		else $error("down step without down edge");
	dir_down_a: assert property (st_reg.ctrl[3][CTL_MODE_MSB:CTL_MODE_LSB] == MODE_UPDN && dn_p[3]
		|-> !st_reg.b_s2[3])
		else $error("down step while direction up");
endmodule // single_phase_pulse_counter
`default_nettype wire

// >>> tb/pulse_source.sv
// Pulse source model: switches and encoders on the counter inputs.
// Assumes one-cycle request strobes from the bench, all on mclk.
`timescale 1ns/10ps
`default_nettype none
module pulse_source
#(
	parameter int W = 10
)
(
	input wire logic mclk,
	input wire logic rstn,
	input wire logic [W-1:0] req,
	input wire logic [2:0] hold,
	output logic [W-1:0] lvl
);
	logic [2:0] cnt [W];

	// One clean high level per strobe, held 1 to 7 cycles, slow or prompt
	always_ff @(posedge mclk)
	begin
		for (int i = 0; i < W; i++)
		begin
			if (!rstn)
				cnt[i] <= 3'h0;
			else if (req[i])
				cnt[i] <= hold;
			else if (cnt[i] != 3'h0)
				cnt[i] <= cnt[i] - 3'h1;
		end
	end

	// Line is low whenever no pulse stands
	always_comb
	begin
		for (int i = 0; i < W; i++)
			lvl[i] = (cnt[i] != 3'h0);
	end
endmodule // pulse_source
`default_nettype wire

// >>> tb/single_phase_pulse_counter_bench.sv
// Self-checking bench for the pulse counter: AHB-Lite master, scan ticks, pulse source.
// Assumes zero-wait slave answers and snapshot/status updates at scan_tick.
`timescale 1ns/10ps
`default_nettype none
module single_phase_pulse_counter_bench
	import pulse_counter_pkg::*;
;
	logic mclk = 1'b0;
	logic rstn = 1'b0;
	logic scan_tick = 1'b0;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [9:0] req = 10'h0;
	logic [2:0] hold = 3'h1;
	logic [3:0] dir_lvl = 4'h0;
	logic [9:0] src;
	logic [3:0] aux;
	logic [3:0] compare_out;
	logic [31:0] hrdata;
	logic [31:0] q;
	logic [31:0] v;
	logic hreadyout;
	logic hresp;
	int r;
	int n;
	int e;
	int seed = 22;
	int error_cnt = 0;
	int total_checks = 0;
	logic [5:0] offs [5] = '{OFF_TARGET_ONE_UPPER, OFF_TARGET_TWO_LOWER, OFF_RELOAD_VALUE_UPPER, OFF_CONTROL, 6'h2c};

	// Direction level shares the down-pulse line
	assign aux = src[7:4] | dir_lvl;
	always #10 mclk = ~mclk;

	single_phase_pulse_counter u_single_phase_pulse_counter (.mclk(mclk), .rstn(rstn), .ce(1'b1),
		.scan_tick(scan_tick), .pulse_in(src[3:0]), .aux_in(aux), .reset_pin_ch1(src[8]),
		.reset_pin_ch4(src[9]), .compare_out(compare_out), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp));
	pulse_source #(.W(10)) u_pulse_source (.mclk(mclk), .rstn(rstn), .req(req), .hold(hold), .lvl(src));

	task automatic close_out;
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] g);
		total_checks++;
		if (g !== ex)
		begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", nm, ex, g);
		end
	endtask

	// One single transfer; waits on hready in both phases
	task automatic bus(input logic w, input logic [1:0] c, input logic [5:0] o, input logic [31:0] d);
		@(posedge mclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, c, o};
		do @(posedge mclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge mclk); while (hreadyout !== 1'b1);
		q = hrdata;
		chk("response", 32'h0, {31'h0, hresp});
	endtask

	task automatic scan;
		@(posedge mclk);
		scan_tick <= 1'b1;
		@(posedge mclk);
		scan_tick <= 1'b0;
	endtask

	// Random hold length; long low gap so edges never merge
	task automatic pls(input logic [9:0] m, input int k);
		repeat (k)
		begin
			@(posedge mclk);
			req <= m;
			hold <= 3'(1 + {$random(seed)} % 6);
			@(posedge mclk);
			req <= 10'h0;
			repeat (12) @(posedge mclk);
		end
	endtask

	// Pulses, one scan, then snapshot and status checked
	task automatic step(input logic [1:0] c, input logic [9:0] m, input int k, input logic [31:0] ec,
		input logic [4:0] es);
		pls(m, k);
		scan;
		bus(1'b0, c, OFF_COUNT_NOW_UPPER, 32'h0);
		v = {q[15:0], 16'h0};
		bus(1'b0, c, OFF_COUNT_NOW_LOWER, 32'h0);
		v[15:0] = q[15:0];
		chk("count", ec, v);
		bus(1'b0, c, OFF_STATUS, 32'h0);
		chk("status", {27'h0, es}, {27'h0, q[4:0]});
	endtask

	function automatic int nxt(input int c, input int t);
		return (c + 1 == t) ? 0 : c + 1;
	endfunction

	initial
	begin
		repeat (20000) @(posedge mclk);
		error_cnt++;
		close_out;
	end

	initial
	begin
		repeat (6) @(posedge mclk);
		rstn <= 1'b1;
		// Reset words and an unmapped word read zero
		foreach (offs[i])
		begin
			bus(1'b0, 2'h0, offs[i], 32'h0);
			chk("reset word", 32'h0, q);
		end
		bus(1'b1, 2'h2, OFF_COUNT_NOW_UPPER, 32'h1234);
		step(2'h2, 10'h0, 0, 32'h0, 5'h00);
		// Adding channel clears to zero at preset one; dual request and down pulses ignored
		n = 3 + {$random(seed)} % 4;
		bus(1'b1, 2'h1, OFF_TARGET_ONE_LOWER, 32'(n));
		bus(1'b1, 2'h1, OFF_CONTROL, 32'h25);
		bus(1'b1, 2'h1, OFF_COMMAND, 32'h2);
		e = 0;
		for (int i = 0; i < n; i++)
		begin
			e = nxt(e, n);
			step(2'h1, 10'h022, 1, 32'(e), (e == 0) ? 5'h02 : 5'h00);
		end
		pls(10'h002, 1);
		bus(1'b0, 2'h1, OFF_COUNT_NOW_LOWER, 32'h0);
		chk("snapshot", 32'h0, q);
		step(2'h1, 10'h0, 0, 32'h1, 5'h00);
		chk("compare out", 32'h1, {31'h0, compare_out[1]});
		bus(1'b1, 2'h1, OFF_COMMAND, 32'h1);
		@(posedge mclk);
		#1;
		chk("compare out", 32'h0, {31'h0, compare_out[1]});
		bus(1'b1, 2'h1, OFF_CONTROL, 32'h20);
		step(2'h1, 10'h002, 2, 32'h1, 5'h00);
		// Dual-pulse channel with keep on preset one
		r = 2 + {$random(seed)} % 3;
		bus(1'b1, 2'h0, OFF_TARGET_ONE_LOWER, 32'(r + 1));
		bus(1'b1, 2'h0, OFF_TARGET_TWO_LOWER, 32'hff);
		bus(1'b1, 2'h0, OFF_RELOAD_VALUE_LOWER, 32'(r));
		bus(1'b1, 2'h0, OFF_CONTROL, 32'h2d);
		bus(1'b1, 2'h0, OFF_COMMAND, 32'h2);
		step(2'h0, 10'h0, 0, 32'(r), 5'h00);
		step(2'h0, 10'h001, 1, 32'(r + 1), 5'h02);
		chk("compare out", 32'h1, {31'h0, compare_out[0]});
		step(2'h0, 10'h001, 1, 32'(r + 2), 5'h00);
		step(2'h0, 10'h010, 1, 32'(r + 1), 5'h02);
		step(2'h0, 10'h010, r + 1, 32'(r), 5'h10);
		step(2'h0, 10'h100, 1, 32'(r), 5'h01);
		bus(1'b1, 2'h0, OFF_COMMAND, 32'h2);
		step(2'h0, 10'h0, 0, 32'(r), 5'h00);
		// Full-range reload, then step off the top
		bus(1'b1, 2'h0, OFF_RELOAD_VALUE_UPPER, 32'hffff);
		bus(1'b1, 2'h0, OFF_RELOAD_VALUE_LOWER, 32'hffff);
		bus(1'b1, 2'h0, OFF_COMMAND, 32'h2);
		step(2'h0, 10'h001, 1, 32'hffffffff, 5'h08);
		// Direction-select channel
		bus(1'b1, 2'h3, OFF_TARGET_ONE_LOWER, 32'h50);
		bus(1'b1, 2'h3, OFF_TARGET_TWO_LOWER, 32'h60);
		bus(1'b1, 2'h3, OFF_RELOAD_VALUE_LOWER, 32'h1);
		bus(1'b1, 2'h3, OFF_CONTROL, 32'h06);
		bus(1'b1, 2'h3, OFF_COMMAND, 32'h2);
		dir_lvl <= 4'h8;
		step(2'h3, 10'h008, 1, 32'h2, 5'h00);
		dir_lvl <= 4'h0;
		step(2'h3, 10'h008, 1, 32'h1, 5'h00);
		step(2'h3, 10'h008, 1, 32'h1, 5'h10);
		chk("compare out", 32'h0, {30'h0, compare_out[3:2]});
		close_out;
	end
endmodule // single_phase_pulse_counter_bench
`default_nettype wire
